// ### shared/frc_defines.vh
/*
 * Constants for the fail-output and reset-output control block:
 * register offsets, field positions, reset values, mode codes and
 * timing counts derived from the 20 MHz system clock.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define FRC_CLK_HZ 20000000
// test strap filter, least time 64 us, rounded up
`define FRC_TEST_FILT_US 64
`define FRC_TEST_FILT_CYC \
  (((`FRC_CLK_HZ / 1000) * `FRC_TEST_FILT_US + 999) / 1000)
// blink output 1.25 Hz, printed in mHz, 50 % duty
`define FRC_BLINK_MHZ 1250
`define FRC_BLINK_HALF_CYC \
  ((`FRC_CLK_HZ / (2 * `FRC_BLINK_MHZ)) * 1000)
// pulsed output 100 Hz
`define FRC_PULSE_HZ 100
`define FRC_PULSE_PER_CYC (`FRC_CLK_HZ / `FRC_PULSE_HZ)
// pulse duty settings in per mille
`define FRC_DUTY_PM0 200
`define FRC_DUTY_PM1 100
`define FRC_DUTY_PM2 50
`define FRC_DUTY_PM3 25
// reset filter and reset delay, plain defaults
`define FRC_RST_FILT_US 10
`define FRC_RST_FILT_CYC ((`FRC_CLK_HZ / 1000000) * `FRC_RST_FILT_US)
`define FRC_RST_DLY_MS 10
`define FRC_RST_DLY_CYC ((`FRC_CLK_HZ / 1000) * `FRC_RST_DLY_MS)

// ---------------------------------------------------------------
// operating modes on the mode input
// ---------------------------------------------------------------
`define FRC_MODE_INIT 3'h0
`define FRC_MODE_NORMAL 3'h1
`define FRC_MODE_STOP 3'h2
`define FRC_MODE_SLEEP 3'h3
`define FRC_MODE_RESTART 3'h4
`define FRC_MODE_FAILSAFE 3'h5

// ---------------------------------------------------------------
// register map (byte offsets) and fields
// ---------------------------------------------------------------
`define FRC_OFS_CTRL 4'h0
`define FRC_OFS_PINCFG 4'h4
`define FRC_OFS_STAT 4'h8
// control register
`define FRC_CTRL_MODE_LSB 0
`define FRC_CTRL_SOFTRST_CMD 2'h3
`define FRC_CTRL_SRPULSE_BIT 2
`define FRC_CTRL_FOTEST_BIT 3
`define FRC_CTRL_UVSEL_LSB 4
`define FRC_CTRL_RST 4'h4
// pin configuration register
`define FRC_PCFG_DUTY_LSB 0
`define FRC_PCFG_BCFG_LSB 2
`define FRC_PCFG_PCFG_LSB 5
`define FRC_PCFG_BSW_BIT 8
`define FRC_PCFG_PSW_BIT 9
`define FRC_PCFG_RST 10'h000
// pin function codes
`define FRC_PIN_FAIL 3'h0
`define FRC_PIN_OFF 3'h1
`define FRC_PIN_WAKE 3'h2
`define FRC_PIN_LS 3'h3
`define FRC_PIN_HS 3'h4
// status register
`define FRC_STAT_FAIL_BIT 0

`endif

// ### hdl/frc_wave.v
/*
 * Blink and pulsed waveform generator for the fail outputs.
 * Assumes the system clock at the rate the counts were made for and
 * an activity level from the same clock domain.
 */
`timescale 1ns/1ps
`include "frc_defines.vh"

module frc_wave #(
  parameter [31:0] BLINK_HALF = `FRC_BLINK_HALF_CYC,
  parameter [31:0] PULSE_PER = `FRC_PULSE_PER_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // control
  input wire active_i,
  input wire [1:0] duty_sel_i,
  // waveforms, high while the pin is pulled low
  output reg blink_o,
  output reg pulse_o
);

  reg [31:0] blink_cnt_r;
  reg [31:0] pulse_cnt_r;
  reg blink_ph_r;

  // -------------------------------------------------------------
  // duty decode
  // -------------------------------------------------------------
  function [31:0] on_cycles;
    input [1:0] sel;
    input [31:0] per;
    reg [31:0] pm;
    begin
      case (sel)
        2'h0: pm = `FRC_DUTY_PM0;
        2'h1: pm = `FRC_DUTY_PM1;
        2'h2: pm = `FRC_DUTY_PM2;
        default: pm = `FRC_DUTY_PM3;
      endcase
      on_cycles = (per * pm) / 32'd1000;
    end
  endfunction

  // counters from oscillator cycles, idle when inactive
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_ph_r <= 1'b0;
      blink_cnt_r <= 32'h0;
      pulse_cnt_r <= 32'h0;
      blink_o <= 1'b0;
      pulse_o <= 1'b0;
    end else if (!active_i) begin
      blink_ph_r <= 1'b0;
      blink_cnt_r <= 32'h0;
      pulse_cnt_r <= 32'h0;
      blink_o <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      // blink: first half pulled, toggle every half period
      if (blink_cnt_r >= BLINK_HALF - 32'd1) begin
        blink_cnt_r <= 32'h0;
        blink_ph_r <= ~blink_ph_r;
        blink_o <= blink_ph_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'd1;
        blink_o <= ~blink_ph_r; // phase held, no stray restart
      end
      // pulsed: on for the selected share of each period
      if (pulse_cnt_r >= PULSE_PER - 32'd1) begin
        pulse_cnt_r <= 32'h0;
      end else begin
        pulse_cnt_r <= pulse_cnt_r + 32'd1;
      end
      pulse_o <= (pulse_cnt_r < on_cycles(duty_sel_i, PULSE_PER));
    end
  end

endmodule

// ### hdl/frc_top.v
/*
 * Fail-output and reset-output control with an AHB-Lite register port.
 * Drives the static, blink and pulsed fail pins (open drain, with
 * alternate switch and wake functions), filters the test strap and
 * runs the reset output sequencing including the soft reset.
 * Assumes the operating mode, failure and watchdog status come from
 * the surrounding mode logic; undervoltage, supply and pins come in raw.
 */
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "frc_defines.vh"

module frc_top #(
  parameter [31:0] BLINK_HALF = `FRC_BLINK_HALF_CYC,
  parameter [31:0] PULSE_PER = `FRC_PULSE_PER_CYC,
  parameter [31:0] RST_DLY = `FRC_RST_DLY_CYC,
  parameter [31:0] RST_FILT = `FRC_RST_FILT_CYC,
  parameter [31:0] TEST_FILT = `FRC_TEST_FILT_CYC
) (
  // clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // ahb-lite slave
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output wire HREADYOUT_O,
  output wire HRESP_O,
  // mode logic status, same clock
  input wire [2:0] MODE_I,
  input wire FAIL_EVENT_I,
  input wire WDG_FAIL_I,
  output reg SOFT_RESET_O,
  output wire [1:0] UV_THRESH_SEL_O,
  // analog status, asynchronous
  input wire UNDERVOLT_I,
  input wire SUPPLY_OK_I,
  // static fail pin
  output wire STATIC_FAIL_OUT_O,
  output reg STATIC_FAIL_OUT_OE_O,
  // blink fail pin
  input wire BLINK_FAIL_OUT_I,
  output reg BLINK_FAIL_OUT_O,
  output reg BLINK_FAIL_OUT_OE_O,
  // pulsed fail / test strap pin
  input wire PULSED_FAIL_OUT_STRAP_PIN_I,
  output reg PULSED_FAIL_OUT_STRAP_PIN_O,
  output reg PULSED_FAIL_OUT_STRAP_PIN_OE_O,
  // reset output pin
  output wire RESET_OUTPUT_PIN_O,
  output reg RESET_OUTPUT_PIN_OE_O,
  // pin status
  output wire [1:0] WAKE_EN_O,
  output wire [1:0] PIN_LEVEL_O,
  output wire TEST_LEVEL_O
);

  // reset sequencer states
  localparam [3:0] ST_HIGH = 4'b0001;
  localparam [3:0] ST_FILT = 4'b0010;
  localparam [3:0] ST_LOW = 4'b0100;
  localparam [3:0] ST_DLY = 4'b1000;

  reg [3:0] ctrl_r;
  reg [9:0] pcfg_r;
  reg fail_r;
  reg wr_pend_r;
  reg [3:0] wr_addr_r;
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg test_lvl_r;
  reg [31:0] test_cnt_r;
  reg [3:0] rst_st_r;
  reg [3:0] rst_st_nxt;
  reg [31:0] rst_cnt_r;
  reg [31:0] rst_cnt_nxt;
  wire addr_ph;
  wire norm_mode;
  wire soft_ok;
  wire soft_go;
  wire fo_active;
  wire blink_w;
  wire pulse_w;
  wire uv_s;
  wire sup_ok_s;
  wire [2:0] bcfg;
  wire [2:0] pcfg;
  wire switch_off;

  // -------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------
  assign HREADYOUT_O = 1'b1; // zero wait states
  assign HRESP_O = 1'b0; // always okay
  assign addr_ph = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign norm_mode = (MODE_I == `FRC_MODE_NORMAL);
  assign soft_ok = norm_mode | (MODE_I == `FRC_MODE_STOP);
  // mode field 11 written in an allowed mode
  assign soft_go = wr_pend_r & (wr_addr_r == `FRC_OFS_CTRL) & soft_ok &
    (HWDATA_I[`FRC_CTRL_MODE_LSB+1:`FRC_CTRL_MODE_LSB] ==
     `FRC_CTRL_SOFTRST_CMD);

  // register read value for an address
  function [31:0] rd_mux;
    input [3:0] a;
    input [3:0] c;
    input [9:0] p;
    input [4:0] s;
    begin
      case (a)
        `FRC_OFS_CTRL: rd_mux = {26'h0, c, 2'h0};
        `FRC_OFS_PINCFG: rd_mux = {22'h0, p};
        `FRC_OFS_STAT: rd_mux = {27'h0, s};
        default: rd_mux = 32'h0;
      endcase
    end
  endfunction

  // address phase capture and read data
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 4'h0;
      HRDATA_O <= 32'h0;
    end else begin
      wr_pend_r <= addr_ph & HWRITE_I;
      wr_addr_r <= (HADDR_I[31:4] == 28'h0) ? HADDR_I[3:0] : 4'hF;
      if (addr_ph && !HWRITE_I) begin
        HRDATA_O <= (HADDR_I[31:4] == 28'h0) ?
          rd_mux(HADDR_I[3:0], ctrl_r, pcfg_r,
                 {test_lvl_r, fo_active, RESET_OUTPUT_PIN_OE_O,
                  uv_s, fail_r}) : 32'h0;
      end
    end
  end

  // -------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------
  // control and pin configuration, defaults reloaded on soft reset
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_r <= `FRC_CTRL_RST >> `FRC_CTRL_SRPULSE_BIT;
      pcfg_r <= `FRC_PCFG_RST;
      SOFT_RESET_O <= 1'b0;
    end else begin
      SOFT_RESET_O <= soft_go; // back to init
      if (soft_go) begin
        ctrl_r <= `FRC_CTRL_RST >> `FRC_CTRL_SRPULSE_BIT;
        pcfg_r <= `FRC_PCFG_RST;
      end else if (wr_pend_r && wr_addr_r == `FRC_OFS_CTRL) begin
        ctrl_r <= HWDATA_I[5:2]; // reset pulse, test activation and threshold select
      end else if (wr_pend_r && wr_addr_r == `FRC_OFS_PINCFG &&
                   norm_mode) begin
        pcfg_r <= HWDATA_I[9:0]; // kept outside normal mode
      end
    end
  end

  assign UV_THRESH_SEL_O = ctrl_r[3:2]; // lowest threshold by default

  // failure flag: set wins over the clear, cleared in normal mode
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fail_r <= 1'b0;
    end else if (FAIL_EVENT_I) begin
      fail_r <= 1'b1;
    end else if (wr_pend_r && wr_addr_r == `FRC_OFS_STAT && norm_mode &&
                 HWDATA_I[`FRC_STAT_FAIL_BIT]) begin
      fail_r <= 1'b0; // held through restart into normal
    end
  end

  // -------------------------------------------------------------
  // pin synchronisers and strap filter
  // -------------------------------------------------------------
  // two stages for every asynchronous input
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1_r <= 4'hB; // supply taken as good, pins idle high
      sync2_r <= 4'hB;
    end else begin
      sync1_r <= {SUPPLY_OK_I, UNDERVOLT_I, BLINK_FAIL_OUT_I,
                  PULSED_FAIL_OUT_STRAP_PIN_I};
      sync2_r <= sync1_r;
    end
  end

  assign uv_s = sync2_r[2];
  assign sup_ok_s = sync2_r[3];
  assign PIN_LEVEL_O = sync2_r[1:0];
  assign TEST_LEVEL_O = test_lvl_r;

  // strap level accepted after staying stable for the filter time
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      test_lvl_r <= 1'b1; // host keeps the strap high
      test_cnt_r <= 32'h0;
    end else if (sync2_r[0] == test_lvl_r) begin
      test_cnt_r <= 32'h0;
    end else if (test_cnt_r >= TEST_FILT - 32'd1) begin
      test_lvl_r <= sync2_r[0];
      test_cnt_r <= 32'h0;
    end else begin
      test_cnt_r <= test_cnt_r + 32'd1;
    end
  end

  // -------------------------------------------------------------
  // fail outputs
  // -------------------------------------------------------------
  assign fo_active = fail_r | ctrl_r[1]; // test activation bit
  assign bcfg = pcfg_r[4:2];
  assign pcfg = pcfg_r[7:5];
  assign switch_off = (MODE_I == `FRC_MODE_RESTART) |
                      (MODE_I == `FRC_MODE_FAILSAFE);
  // wake capable except in fail-safe
  assign WAKE_EN_O[0] = (pcfg == `FRC_PIN_WAKE) &
                        (MODE_I != `FRC_MODE_FAILSAFE);
  assign WAKE_EN_O[1] = (bcfg == `FRC_PIN_WAKE) &
                        (MODE_I != `FRC_MODE_FAILSAFE);
  assign STATIC_FAIL_OUT_O = 1'b0; // open drain
  assign RESET_OUTPUT_PIN_O = 1'b0; // open drain

  frc_wave #(
    .BLINK_HALF(BLINK_HALF),
    .PULSE_PER(PULSE_PER)
  ) u_wave (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .active_i(fo_active),
    .duty_sel_i(pcfg_r[1:0]),
    .blink_o(blink_w),
    .pulse_o(pulse_w)
  );

  // pin drive per configured function and mode
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      STATIC_FAIL_OUT_OE_O <= 1'b0;
      BLINK_FAIL_OUT_O <= 1'b0;
      BLINK_FAIL_OUT_OE_O <= 1'b0;
      PULSED_FAIL_OUT_STRAP_PIN_O <= 1'b0;
      PULSED_FAIL_OUT_STRAP_PIN_OE_O <= 1'b0;
    end else begin
      STATIC_FAIL_OUT_OE_O <= fo_active;
      BLINK_FAIL_OUT_O <= (bcfg == `FRC_PIN_HS) & ~switch_off;
      PULSED_FAIL_OUT_STRAP_PIN_O <= (pcfg == `FRC_PIN_HS) & ~switch_off;
      case (bcfg)
        `FRC_PIN_FAIL: BLINK_FAIL_OUT_OE_O <= blink_w;
        `FRC_PIN_LS, `FRC_PIN_HS:
          BLINK_FAIL_OUT_OE_O <= pcfg_r[8] & ~switch_off;
        default: BLINK_FAIL_OUT_OE_O <= 1'b0;
      endcase
      case (pcfg)
        `FRC_PIN_FAIL: PULSED_FAIL_OUT_STRAP_PIN_OE_O <= pulse_w;
        `FRC_PIN_LS, `FRC_PIN_HS:
          PULSED_FAIL_OUT_STRAP_PIN_OE_O <= pcfg_r[9] & ~switch_off;
        default: PULSED_FAIL_OUT_STRAP_PIN_OE_O <= 1'b0;
      endcase
    end
  end

  // -------------------------------------------------------------
  // reset output sequencer
  // -------------------------------------------------------------
  // next state of the reset line
  always @* begin
    rst_st_nxt = rst_st_r;
    rst_cnt_nxt = rst_cnt_r + 32'd1;
    case (rst_st_r)
      ST_HIGH: begin
        rst_cnt_nxt = 32'h0;
        if (WDG_FAIL_I || (soft_go && ctrl_r[0])) begin
          rst_st_nxt = ST_LOW;
        end else if (uv_s) begin
          rst_st_nxt = ST_FILT;
        end
      end
      ST_FILT: begin
        if (WDG_FAIL_I || (soft_go && ctrl_r[0])) begin
          rst_st_nxt = ST_LOW;
          rst_cnt_nxt = 32'h0;
        end else if (!uv_s) begin
          rst_st_nxt = ST_HIGH;
          rst_cnt_nxt = 32'h0;
        end else if (rst_cnt_r >= RST_FILT - 32'd1) begin
          rst_st_nxt = ST_LOW;
          rst_cnt_nxt = 32'h0;
        end
      end
      ST_LOW: begin
        rst_cnt_nxt = 32'h0;
        if (!uv_s) begin
          rst_st_nxt = ST_DLY; // event gone, start delay
        end
      end
      ST_DLY: begin
        if (uv_s || WDG_FAIL_I) begin
          rst_st_nxt = ST_LOW;
          rst_cnt_nxt = 32'h0;
        end else if (rst_cnt_r >= RST_DLY - 32'd1) begin
          rst_st_nxt = ST_HIGH;
          rst_cnt_nxt = 32'h0;
        end
      end
      default: begin
        rst_st_nxt = ST_LOW;
        rst_cnt_nxt = 32'h0;
      end
    endcase
  end

  // reset line state, low from power-up
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_st_r <= ST_LOW;
      rst_cnt_r <= 32'h0;
      RESET_OUTPUT_PIN_OE_O <= 1'b0;
    end else begin
      rst_st_r <= rst_st_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      // drive low only while the synchronised supply status is good
      RESET_OUTPUT_PIN_OE_O <= sup_ok_s &
        ((rst_st_nxt == ST_LOW) | (rst_st_nxt == ST_DLY));
    end
  end

endmodule

// ### test/frc_top_asserts.sv
/* Concurrent checks on the fail and reset pins of frc_top.
   Assumes one clock, async active-low reset, bound at the foot. */
`timescale 1ns/1ps
`include "frc_defines.vh"
module frc_top_asserts #(
  parameter [31:0] RST_DLY = 32'h14
) (
  // clock, reset and mode status
  input wire CLK_I,
  input wire RST_B_I,
  input wire [2:0] MODE_I,
  input wire FAIL_EVENT_I,
  input wire WDG_FAIL_I,
  input wire UNDERVOLT_I,
  input wire SUPPLY_OK_I,
  // watched outputs
  input wire SOFT_RESET_O,
  input wire [1:0] UV_THRESH_SEL_O,
  input wire STATIC_FAIL_OUT_OE_O,
  input wire BLINK_FAIL_OUT_O,
  input wire PULSED_FAIL_OUT_STRAP_PIN_O,
  input wire RESET_OUTPUT_PIN_OE_O,
  input wire [1:0] WAKE_EN_O
);
  // ---------------------------------------------------------------
  // helper logic and sequences
  // ---------------------------------------------------------------
  reg [31:0] hi_cnt_r;
  // cycles the reset line has been pulled low so far
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      hi_cnt_r <= 32'h0;
    else if (RESET_OUTPUT_PIN_OE_O)
      hi_cnt_r <= hi_cnt_r + 32'h1;
    else
      hi_cnt_r <= 32'h0;
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence uv_held_s;
    (UNDERVOLT_I && SUPPLY_OK_I) [*8];
  endsequence
  sequence sup_ok_s;
    SUPPLY_OK_I [*5];
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  static_follow_a:
    assert property (FAIL_EVENT_I |-> ##[1:2] STATIC_FAIL_OUT_OE_O)
    else $error("static fail pin not pulled after a failure");
  switch_off_a:
    assert property ((MODE_I == `FRC_MODE_RESTART ||
      MODE_I == `FRC_MODE_FAILSAFE) [*3] |->
      !BLINK_FAIL_OUT_O && !PULSED_FAIL_OUT_STRAP_PIN_O)
    else $error("switch drive seen in restart or fail-safe");
  wake_off_a:
    assert property (MODE_I == `FRC_MODE_FAILSAFE |-> WAKE_EN_O == 2'h0)
    else $error("wake capability left on in fail-safe");
  uv_low_a:
    assert property (uv_held_s |-> ##[0:2] RESET_OUTPUT_PIN_OE_O)
    else $error("reset line not pulled on undervoltage");
  reset_hold_a:
    assert property (sup_ok_s ##0 $fell(RESET_OUTPUT_PIN_OE_O) |->
      hi_cnt_r >= RST_DLY - 32'h1)
    else $error("reset line released before the delay ran out");
  wdg_low_a:
    assert property (sup_ok_s ##0 WDG_FAIL_I |->
      ##[1:2] RESET_OUTPUT_PIN_OE_O)
    else $error("reset line not pulled on watchdog failure");
  sr_single_a:
    assert property (SOFT_RESET_O |=> !SOFT_RESET_O)
    else $error("soft reset request longer than one cycle");
  sr_mode_a:
    assert property (SOFT_RESET_O |-> $past(MODE_I) == `FRC_MODE_NORMAL
      || $past(MODE_I) == `FRC_MODE_STOP)
    else $error("soft reset taken outside normal or stop");
  sr_default_a:
    assert property (SOFT_RESET_O |-> ##[0:1] UV_THRESH_SEL_O == 2'h0)
    else $error("threshold select not reloaded by soft reset");
  uv_default_a:
    assert property ($rose(RST_B_I) |-> UV_THRESH_SEL_O == 2'h0)
    else $error("threshold select not lowest after reset");
endmodule

bind frc_top frc_top_asserts #(.RST_DLY(RST_DLY)) u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .MODE_I(MODE_I),
  .FAIL_EVENT_I(FAIL_EVENT_I), .WDG_FAIL_I(WDG_FAIL_I),
  .UNDERVOLT_I(UNDERVOLT_I), .SUPPLY_OK_I(SUPPLY_OK_I),
  .SOFT_RESET_O(SOFT_RESET_O), .UV_THRESH_SEL_O(UV_THRESH_SEL_O),
  .STATIC_FAIL_OUT_OE_O(STATIC_FAIL_OUT_OE_O),
  .BLINK_FAIL_OUT_O(BLINK_FAIL_OUT_O),
  .PULSED_FAIL_OUT_STRAP_PIN_O(PULSED_FAIL_OUT_STRAP_PIN_O),
  .RESET_OUTPUT_PIN_OE_O(RESET_OUTPUT_PIN_OE_O), .WAKE_EN_O(WAKE_EN_O));

// ### test/frc_host_model.sv
/* Host and lamp side of the fail and reset pins.
   Assumes pulled-up open-drain lines and a host strap driver. */
`timescale 1ns/1ps
module frc_host_model (
  // host strap control
  input wire init_i,
  input wire strap_low_i,
  // pin drives from the block
  input wire blink_out_i,
  input wire blink_oe_i,
  input wire pulse_out_i,
  input wire pulse_oe_i,
  input wire reset_oe_i,
  // resolved line levels
  output wire blink_lvl_o,
  output wire pulse_lvl_o,
  output wire reset_n_o
);
  // pulled-up lines, low only while a driver sinks them
  assign blink_lvl_o = blink_oe_i ? blink_out_i : 1'b1;
  // host keeps the strap high through power-up and init
  assign pulse_lvl_o = pulse_oe_i ? pulse_out_i : !(strap_low_i && !init_i);
  assign reset_n_o = !reset_oe_i; // pull-up on the reset line
endmodule

// ### test/fail_output_and_reset_control_bench.sv
/* Self-checking bench for frc_top with shortened timing counts.
   Assumes the host model and the bound checker beside it. */
`timescale 1ns/1ps
`include "frc_defines.vh"
module fail_output_and_reset_control_bench;
  localparam integer BH = 20;
  localparam integer PP = 200;
  localparam integer RD = 20;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg hsel = 1'b0, hwrite = 1'b0, fail_ev = 1'b0, wdg = 1'b0, uv = 1'b0;
  reg sup = 1'b1, strap_low = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] mode = `FRC_MODE_INIT;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hready, sr, soe, blo, bloe, puo, puoe, roe, test, bl_lvl, pu_lvl;
  wire ro_n;
  wire [1:0] uvsel, wake, pinlvl;
  integer num_errors = 0, checks_done = 0, c_sr, c_ro, c_bl, c_pu, i;
  integer pm [0:3] = '{`FRC_DUTY_PM0, `FRC_DUTY_PM1, `FRC_DUTY_PM2,
    `FRC_DUTY_PM3};

  // ---------------------------------------------------------------
  // block, host model and clock
  // ---------------------------------------------------------------
  frc_top #(.BLINK_HALF(BH), .PULSE_PER(PP), .RST_DLY(RD), .RST_FILT(4),
    .TEST_FILT(8)) uut (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .MODE_I(mode),
    .FAIL_EVENT_I(fail_ev), .WDG_FAIL_I(wdg), .SOFT_RESET_O(sr),
    .UV_THRESH_SEL_O(uvsel), .UNDERVOLT_I(uv), .SUPPLY_OK_I(sup),
    .STATIC_FAIL_OUT_O(), .STATIC_FAIL_OUT_OE_O(soe),
    .BLINK_FAIL_OUT_I(bl_lvl), .BLINK_FAIL_OUT_O(blo),
    .BLINK_FAIL_OUT_OE_O(bloe), .PULSED_FAIL_OUT_STRAP_PIN_I(pu_lvl),
    .PULSED_FAIL_OUT_STRAP_PIN_O(puo),
    .PULSED_FAIL_OUT_STRAP_PIN_OE_O(puoe), .RESET_OUTPUT_PIN_O(),
    .RESET_OUTPUT_PIN_OE_O(roe), .WAKE_EN_O(wake), .PIN_LEVEL_O(pinlvl),
    .TEST_LEVEL_O(test));
  frc_host_model host (.init_i(!rst_b || mode == `FRC_MODE_INIT),
    .strap_low_i(strap_low), .blink_out_i(blo), .blink_oe_i(bloe),
    .pulse_out_i(puo), .pulse_oe_i(puoe), .reset_oe_i(roe),
    .blink_lvl_o(bl_lvl), .pulse_lvl_o(pu_lvl), .reset_n_o(ro_n));
  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer, waits on ready in both phases
  task ahb(input w, input [31:0] a, input [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task wr(input [31:0] a, input [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rdc(input [31:0] a, input [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task setm(input [2:0] m);
    @(posedge clk) mode <= m;
  endtask
  // counts pulled cycles of the watched pins at falling edges
  task watch(input integer n);
    c_sr = 0;
    c_ro = 0;
    c_bl = 0;
    c_pu = 0;
    repeat (n) begin
      @(negedge clk);
      c_sr = c_sr + sr;
      c_ro = c_ro + roe;
      c_bl = c_bl + bloe;
      c_pu = c_pu + puoe;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_power;
    watch(2);
    chk(roe, 1'b1);
    watch(RD + 2);
    chk(ro_n, 1'b1);
    chk({uvsel, test}, 3'h1);
    rdc(`FRC_OFS_CTRL, 32'h4);
    rdc(`FRC_OFS_PINCFG, 32'h0);
    rdc(32'hC, 32'h0);
  endtask
  task t_cfg;
    setm(`FRC_MODE_STOP);
    wr(`FRC_OFS_PINCFG, 32'h3);
    rdc(`FRC_OFS_PINCFG, 32'h0);
    setm(`FRC_MODE_NORMAL);
    wr(`FRC_OFS_PINCFG, 32'h3);
    rdc(`FRC_OFS_PINCFG, 32'h3);
    wr(`FRC_OFS_CTRL, 32'h34);
    watch(2);
    chk(uvsel, 2'h3);
  endtask
  task t_wave;
    watch(PP);
    chk(c_pu + c_bl, 0);
    @(posedge clk) fail_ev <= 1'b1;
    @(posedge clk) fail_ev <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      wr(`FRC_OFS_PINCFG, i);
      watch(PP);
      watch(PP);
      chk(c_pu, PP * pm[i] / 1000);
    end
    watch(2 * BH);
    chk({c_bl, soe}, {BH, 1'b1});
  endtask
  task t_restart;
    setm(`FRC_MODE_RESTART);
    watch(4);
    chk(soe, 1'b1);
    setm(`FRC_MODE_NORMAL);
    watch(4);
    chk(soe, 1'b1);
    wr(`FRC_OFS_STAT, 32'h1);
    wr(`FRC_OFS_PINCFG, 32'h150);
    watch(4);
    chk({soe, blo, wake[0]}, 3'h3);
    setm(`FRC_MODE_RESTART);
    watch(4);
    chk({blo, wake[0]}, 2'h1);
    rdc(`FRC_OFS_PINCFG, 32'h150);
    setm(`FRC_MODE_FAILSAFE);
    watch(4);
    chk(wake, 2'h0);
    setm(`FRC_MODE_NORMAL);
    watch(4);
    chk({blo, wake[0]}, 2'h3);
    wr(`FRC_OFS_PINCFG, 32'h28C);
    watch(4);
    chk({puo, puoe, blo, bloe}, 4'hC);
    setm(`FRC_MODE_FAILSAFE);
    watch(4);
    chk({puo, puoe}, 2'h0);
    setm(`FRC_MODE_NORMAL);
    wr(`FRC_OFS_PINCFG, 32'h0);
  endtask
  task t_rline;
    @(posedge clk) uv <= 1'b1;
    watch(3);
    chk(roe, 1'b0);
    watch(8);
    chk(roe, 1'b1);
    @(posedge clk) sup <= 1'b0;
    watch(4);
    chk(roe, 1'b0);
    @(posedge clk) sup <= 1'b1;
    watch(4);
    chk(roe, 1'b1);
    @(posedge clk) uv <= 1'b0;
    watch(RD - 2);
    chk(roe, 1'b1);
    watch(8);
    chk(roe, 1'b0);
    @(posedge clk) wdg <= 1'b1;
    @(posedge clk) wdg <= 1'b0;
    watch(2);
    chk(roe, 1'b1);
    watch(RD + 4);
    chk(roe, 1'b0);
  endtask
  task t_soft;
    setm(`FRC_MODE_SLEEP);
    wr(`FRC_OFS_CTRL, 32'h37);
    watch(5);
    chk(c_sr, 0);
    rdc(`FRC_OFS_CTRL, 32'h34);
    setm(`FRC_MODE_STOP);
    wr(`FRC_OFS_CTRL, 32'h37);
    watch(5);
    chk({c_sr, c_ro > 0, uvsel}, {32'h1, 1'b1, 2'h0});
    rdc(`FRC_OFS_CTRL, 32'h4);
    watch(RD + 4);
    chk(roe, 1'b0);
    setm(`FRC_MODE_NORMAL);
    wr(`FRC_OFS_PINCFG, 32'h1);
    wr(`FRC_OFS_CTRL, 32'h0);
    wr(`FRC_OFS_CTRL, 32'h3);
    watch(8);
    chk(c_sr, 1);
    chk(c_ro, 0);
    rdc(`FRC_OFS_PINCFG, 32'h0);
  endtask
  task t_strap;
    @(posedge clk) strap_low <= 1'b1;
    watch(5);
    chk({pu_lvl, test}, 2'h1);
    watch(10);
    chk(test, 1'b0);
    chk(pinlvl, 2'h2);
    @(posedge clk) strap_low <= 1'b0;
    watch(14);
    chk(test, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ---------------------------------------------------------------
  task end_of_test;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_power;
    t_cfg;
    t_wave;
    t_restart;
    t_rline;
    t_soft;
    t_strap;
    end_of_test;
  end
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    end_of_test;
  end
endmodule
